// ==== pkg/fault_arb_pkg.sv ====
// Package: constants and types for the fault arbitration handler
package fault_arb_pkg;

  // ==========================================================================
  // Supply section sources, index = priority (0 highest)
  // ==========================================================================
  localparam int          SUP_N       = 5;
  localparam logic [2:0]  SUP_UV      = 3'h0;  // Logic-supply undervoltage
  localparam logic [2:0]  SUP_OV      = 3'h1;  // Logic-supply overvoltage
  localparam logic [2:0]  SUP_BUCK_OC = 3'h2;  // Buck overcurrent
  localparam logic [2:0]  SUP_LOG_OC  = 3'h3;  // Logic-supply overcurrent
  localparam logic [2:0]  SUP_SPARE   = 3'h4;  // Lowest supply level

  // ==========================================================================
  // Functional section sources, index = priority (0 highest)
  // ==========================================================================
  localparam int          FUN_N       = 8;
  localparam logic [2:0]  FUN_UV      = 3'h0;  // Logic-supply undervoltage
  localparam logic [2:0]  FUN_PUMP_LS = 3'h1;  // Low-side pump undervoltage
  localparam logic [2:0]  FUN_PUMP_HS = 3'h2;  // High-side pump undervoltage
  localparam logic [2:0]  FUN_OVHEAT  = 3'h3;  // Overheat shutdown
  localparam logic [2:0]  FUN_SHUNT   = 3'h4;  // Shunt overcurrent
  localparam logic [2:0]  FUN_ROTOR   = 3'h5;  // Locked rotor
  localparam logic [2:0]  FUN_WDOG    = 3'h6;  // Watchdog
  localparam logic [2:0]  FUN_NVM     = 3'h7;  // Nvm read/program fault

  // Latched sources in the functional section (bit per source)
  localparam logic [7:0]  FUN_LATCHED = 8'ha8;  // Overheat, rotor, nvm
  // Sources that force gates to high impedance when serviced
  localparam logic [7:0]  FUN_HIZ     = 8'ha9;  // Uv, overheat, rotor, nvm

  // Shunt overcurrent trigger modes
  localparam logic [1:0]  OC_IMMEDIATE = 2'h0;
  localparam logic [1:0]  OC_COUNT8    = 2'h1;
  localparam logic [1:0]  OC_COUNT16   = 2'h2;

  // Section arbiter state
  typedef enum logic [0:0]
  {
    ARB_IDLE = 1'b0,
    ARB_BUSY = 1'b1
  } arb_state_e;

endpackage : fault_arb_pkg

// ==== design/fault_arbitration_handler.sv ====
// Module: two-section fault arbiter with pin, gate actions and status bits
`timescale 1ns/1ps
// ============================================================================
// Overview of operation
// - Supply faults arbitrated, five levels, B0 highest
// - Functional section: first fault served, others only recorded, except pump faults, which force high-z regardless
// - Simultaneous faults: highest priority wins, F0 top
// - Apply action, hold section until cleared
// - Fault pin is OR of both sections, watchdog excluded
// - Non-latched: action stops, status stays set
// - Status bits set for every event
// - Each malfunction event recorded in status immediately
// - Latched faults need the latch-clear field
// - Latched counting shunt fault: clear after quiet period/standby
// - Immediate shunt fault: clear once condition gone
// - Logic supply over-volt/over-current: pin only
// - Logic undervoltage: high-z, halt state, await toggle
// - Shunt fault F4 truncates PWM if configured
// - Shunt brake enabled: brake, treat as latched
// - Locked rotor: high-z, needs driver-enable toggle
// - Overheat shutdown latched, high-z, pin asserted
// - Nvm fault latched, high-z only while it is the served fault
// ============================================================================
module fault_arbitration_handler
(
  // Clock and reset
  input  wire logic                          sys_clk,
  input  wire logic                          rst_n,
  // Raw fault conditions from detectors (asynchronous)
  input  wire logic                          logic_uv_raw,
  input  wire logic                          logic_ov_raw,
  input  wire logic                          logic_oc_raw,
  input  wire logic                          buck_oc_raw,
  input  wire logic                          pump_ls_uv_raw,
  input  wire logic                          pump_hs_uv_raw,
  input  wire logic                          overheat_shutdown_raw,
  input  wire logic                          overheat_warning_raw,
  input  wire logic                          shunt_oc_raw,
  input  wire logic                          rotor_lock_raw,
  input  wire logic                          wdog_raw,
  input  wire logic                          nvm_fault_raw,
  input  wire logic                          chip_enable_raw,
  input  wire logic                          driver_enable_pin,
  // Same-clock context from the device
  input  wire logic                          pwm_period_end,
  input  wire logic                          standby_state,
  input  wire logic                          pump_start_blank,
  input  wire logic                          logic_supply_good,
  // Configuration bits
  input  wire logic [1:0]                    shunt_oc_mode,
  input  wire logic                          shunt_oc_latch_cfg,
  input  wire logic                          shunt_oc_truncate_cfg,
  input  wire logic                          brake_on_shunt_overcurrent,
  input  wire logic                          wdog_latch_cfg,
  // Host clear writes (one-cycle strobes)
  input  wire logic                          clear_faults_field,
  input  wire logic                          latch_clear_field,
  // Pin and actions
  output logic                               fault_out_n,
  output logic                               gate_hiz,
  output logic                               pwm_truncate,
  output logic                               brake,
  output logic                               logic_supply_halt_state,
  // Status
  output logic [fault_arb_pkg::SUP_N-1:0]    supply_fault_status,
  output logic [fault_arb_pkg::FUN_N-1:0]    functional_fault_status,
  output logic                               overheat_warning,
  output logic                               clear_pending
);
  import fault_arb_pkg::*;

  // ==========================================================================
  // Input synchronisers, three stages, change when stages two and three agree
  // ==========================================================================
  localparam int NIN = 14;
  // Reset image: enables idle high, fault levels low, so no false edge follows reset
  localparam logic [NIN-1:0] COND_RST = 14'h3000;
  logic [NIN-1:0] raw_vec;    // Raw asynchronous inputs
  logic [NIN-1:0] s1, s2, s3; // Synchroniser stages
  logic [NIN-1:0] cond;       // Filtered conditions
  assign raw_vec = {driver_enable_pin, chip_enable_raw, nvm_fault_raw, wdog_raw,
                    rotor_lock_raw, shunt_oc_raw, overheat_warning_raw,
                    overheat_shutdown_raw, pump_hs_uv_raw, pump_ls_uv_raw,
                    buck_oc_raw, logic_oc_raw, logic_ov_raw, logic_uv_raw};

  // Sync chain
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s1 <= COND_RST;
      s2 <= COND_RST;
      s3 <= COND_RST;
    end
    else
    begin
      s1 <= raw_vec;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // Agreement filter per bit
  genvar gi;
  generate
    for (gi = 0; gi < NIN; gi++)
    begin : g_filt
      always_ff @(posedge sys_clk or negedge rst_n)
      begin
        if (!rst_n)
          cond[gi] <= COND_RST[gi];
        else if (s2[gi] == s3[gi])
          cond[gi] <= s3[gi];
      end
    end
  endgenerate

  logic c_uv, c_ov, c_loc, c_boc, c_pls, c_phs, c_ots, c_otw, c_shunt, c_rot, c_wd, c_nvm;
  logic c_ce, c_drv, c_ce_d, c_drv_d;
  assign {c_drv, c_ce, c_nvm, c_wd, c_rot, c_shunt, c_otw, c_ots,
          c_phs, c_pls, c_boc, c_loc, c_ov, c_uv} = cond;

  // Previous enables for rising-edge detection
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      c_ce_d  <= 1'b1;  // Idle high: no rise seen at start
      c_drv_d <= 1'b1;
    end
    else
    begin
      c_ce_d  <= c_ce;
      c_drv_d <= c_drv;
    end
  end
  logic ce_rise, drv_rise;
  assign ce_rise  = c_ce & ~c_ce_d;
  assign drv_rise = c_drv & ~c_drv_d;

  // ==========================================================================
  // Source vectors
  // ==========================================================================
  logic [SUP_N-1:0] sup_req; // Supply requests
  logic [FUN_N-1:0] fun_req; // Functional requests
  assign sup_req = {1'b0,
                    c_loc & logic_supply_good,
                    c_boc & logic_supply_good & ~pump_start_blank,
                    c_ov & logic_supply_good,
                    c_uv};
  assign fun_req = {c_nvm, c_wd, c_rot, c_shunt, c_ots, c_phs, c_pls, c_uv};

  // Shunt latched when configured or braking
  logic shunt_latched;
  assign shunt_latched = shunt_oc_latch_cfg | brake_on_shunt_overcurrent;
  logic [FUN_N-1:0] fun_latched;
  assign fun_latched = FUN_LATCHED | ({{(FUN_N-1){1'b0}}, shunt_latched} << FUN_SHUNT)
                     | ({{(FUN_N-1){1'b0}}, wdog_latch_cfg} << FUN_WDOG);

  // Quiet PWM period tracking for counting mode
  logic oc_seen;   // Overcurrent seen in current period
  logic oc_quiet;  // A whole period passed with no event
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      oc_seen  <= 1'b0;
      oc_quiet <= 1'b0;
    end
    else if (c_shunt)
    begin
      oc_seen  <= 1'b1;
      oc_quiet <= 1'b0;
    end
    else if (pwm_period_end)
    begin
      oc_quiet <= ~oc_seen;
      oc_seen  <= 1'b0;
    end
  end

  // Shunt clear permission
  logic shunt_clear_ok;
  assign shunt_clear_ok = (shunt_oc_mode == OC_IMMEDIATE) ? ~c_shunt
                                                          : ((oc_quiet & ~c_shunt) | standby_state);

  // ==========================================================================
  // Priority pick: lowest index wins
  // ==========================================================================
  function automatic logic [2:0] pick(input logic [7:0] req);
    logic [2:0] idx;
    idx = 3'h0;
    for (int i = 7; i >= 0; i--)
      if (req[i])
        idx = 3'(i);
    return idx;
  endfunction

  // ==========================================================================
  // Supply arbiter
  // ==========================================================================
  arb_state_e       sup_state;
  logic [2:0]       sup_idx;
  logic             sup_release; // Serviced supply fault may go
  assign sup_release = ~sup_req[sup_idx] & clear_faults_field & (sup_idx != SUP_UV);

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sup_state <= ARB_IDLE;
      sup_idx   <= 3'h0;
    end
    else
    begin
      unique case (sup_state)
        ARB_IDLE:
          if (|sup_req)
          begin
            sup_state <= ARB_BUSY;
            sup_idx   <= pick({{(8-SUP_N){1'b0}}, sup_req});
          end
        ARB_BUSY:
          if (sup_release || (sup_idx == SUP_UV && ce_rise && !c_uv))
            sup_state <= ARB_IDLE;
      endcase
    end
  end

  // ==========================================================================
  // Functional arbiter
  // ==========================================================================
  arb_state_e       fun_state;
  logic [2:0]       fun_idx;
  logic             fun_cond; // Serviced condition still present
  logic             fun_release;
  assign fun_cond = fun_req[fun_idx];
  always_comb
  begin
    fun_release = 1'b0;
    if (fun_idx == FUN_UV)
      fun_release = ce_rise & ~c_uv;
    else if (fun_idx == FUN_ROTOR)
      fun_release = drv_rise & ~fun_cond;
    else if (fun_idx == FUN_SHUNT && shunt_latched)
      fun_release = latch_clear_field & shunt_clear_ok;
    else if (fun_latched[fun_idx])
      fun_release = latch_clear_field & ~fun_cond;
    else
      fun_release = clear_faults_field & ~fun_cond;
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      fun_state <= ARB_IDLE;
      fun_idx   <= 3'h0;
    end
    else
    begin
      unique case (fun_state)
        ARB_IDLE:
          if (|fun_req)
          begin
            fun_state <= ARB_BUSY;
            fun_idx   <= pick(fun_req);
          end
        ARB_BUSY:
          if (fun_release)
            fun_state <= ARB_IDLE;
      endcase
    end
  end

  // ==========================================================================
  // Actions, pin and halt state
  // ==========================================================================
  logic fun_act; // Serviced action live (non-latched stops with condition)
  assign fun_act = (fun_state == ARB_BUSY) && (fun_latched[fun_idx] || fun_cond);

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      fault_out_n             <= 1'b1;
      gate_hiz                <= 1'b0;
      pwm_truncate            <= 1'b0;
      brake                   <= 1'b0;
      logic_supply_halt_state <= 1'b0;
    end
    else
    begin
      // Pin: OR of both sections; watchdog never drives it
      fault_out_n  <= ~(((sup_state == ARB_BUSY) && sup_req[sup_idx])
                      || (fun_act && (fun_idx != FUN_WDOG)));
      // Pumps force high-z regardless of arbitration
      gate_hiz     <= c_pls | c_phs | logic_supply_halt_state
                    | (fun_act && FUN_HIZ[fun_idx])
                    | (fun_act && fun_idx == FUN_SHUNT && shunt_oc_latch_cfg);
      pwm_truncate <= fun_act && fun_idx == FUN_SHUNT && shunt_oc_truncate_cfg;
      brake        <= fun_act && fun_idx == FUN_SHUNT && brake_on_shunt_overcurrent;
      // Halt on undervoltage until chip-enable toggles
      if (c_uv)
        logic_supply_halt_state <= 1'b1;
      else if (ce_rise)
        logic_supply_halt_state <= 1'b0;
    end
  end

  // ==========================================================================
  // Status bits: set on every event, set beats clear
  // ==========================================================================
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      supply_fault_status     <= '0;
      functional_fault_status <= '0;
      overheat_warning        <= 1'b0;
      clear_pending           <= 1'b0;
    end
    else
    begin
      for (int i = 0; i < SUP_N; i++)
        if (sup_req[i])
          supply_fault_status[i] <= 1'b1;
        else if (clear_faults_field)
          supply_fault_status[i] <= 1'b0;
      for (int i = 0; i < FUN_N; i++)
        if (fun_req[i])
          functional_fault_status[i] <= 1'b1;
        // Status only goes on a write; a refused release keeps it
        else if ((fun_latched[i] ? latch_clear_field : clear_faults_field)
                 && !(fun_state == ARB_BUSY && fun_idx == 3'(i) && !fun_release))
          functional_fault_status[i] <= 1'b0;
      if (c_otw)
        overheat_warning <= 1'b1;
      else if (clear_faults_field)
        overheat_warning <= 1'b0;
      // Strobes self-clear; nothing holds them
      clear_pending <= clear_faults_field | latch_clear_field;
    end
  end

endmodule : fault_arbitration_handler

// ==== sim/fault_arb_sva.sv ====
// Checker: port-level properties of the fault arbitration handler
`timescale 1ns/1ps
module fault_arb_sva
  import fault_arb_pkg::*;
(
  // Clock, reset and watched inputs
  input wire logic               sys_clk,
  input wire logic               rst_n,
  input wire logic               pump_ls_uv_raw,
  input wire logic               shunt_oc_truncate_cfg,
  input wire logic               brake_on_shunt_overcurrent,
  input wire logic               clear_faults_field,
  input wire logic               latch_clear_field,
  // Watched outputs
  input wire logic               fault_out_n,
  input wire logic               gate_hiz,
  input wire logic               pwm_truncate,
  input wire logic               brake,
  input wire logic               logic_supply_halt_state,
  input wire logic [SUP_N-1:0]   supply_fault_status,
  input wire logic [FUN_N-1:0]   functional_fault_status,
  input wire logic               clear_pending
);
  // ==========================================================================
  // Common clocking
  // ==========================================================================
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // Pump supply low long enough to pass the input filter
  sequence s_pump_held;
    pump_ls_uv_raw [*8];
  endsequence
  // Clear echo seen now or one cycle ago
  sequence s_clear_recent;
    clear_pending || $past(clear_pending);
  endsequence
  // ==========================================================================
  // Properties
  // ==========================================================================
  pin_cause_a: assert property ($fell(fault_out_n) |-> (|supply_fault_status) || (|functional_fault_status))
    else $error("fault pin fell with no status");
  fun_hold_a: assert property (|($past(functional_fault_status) & ~functional_fault_status) |-> s_clear_recent)
    else $error("functional status dropped without clear");
  sup_hold_a: assert property (|($past(supply_fault_status) & ~supply_fault_status) |-> s_clear_recent)
    else $error("supply status dropped without clear");
  latch_hold_a: assert property ($fell(functional_fault_status[FUN_OVHEAT])
    |-> $past(latch_clear_field) || $past(latch_clear_field, 2))
    else $error("latched status left without latch clear");
  echo_pulse_a: assert property ((clear_faults_field || latch_clear_field) |=> clear_pending)
    else $error("clear strobe not echoed");
  pump_hiz_a: assert property (s_pump_held |-> ##[0:4] gate_hiz)
    else $error("pump undervoltage did not force high impedance");
  hiz_cause_a: assert property ($rose(gate_hiz) |-> |functional_fault_status)
    else $error("high impedance without functional fault");
  trunc_cfg_a: assert property ($rose(pwm_truncate)
    |-> shunt_oc_truncate_cfg && functional_fault_status[FUN_SHUNT])
    else $error("truncation without shunt fault or enable");
  brake_cfg_a: assert property ($rose(brake) |-> brake_on_shunt_overcurrent)
    else $error("brake without brake enable");
  halt_cause_a: assert property ($rose(logic_supply_halt_state) |-> supply_fault_status[SUP_UV])
    else $error("halt state without logic undervoltage");
endmodule : fault_arb_sva

bind fault_arbitration_handler fault_arb_sva chk_u (.sys_clk, .rst_n, .pump_ls_uv_raw, .shunt_oc_truncate_cfg,
  .brake_on_shunt_overcurrent, .clear_faults_field, .latch_clear_field, .fault_out_n, .gate_hiz, .pwm_truncate,
  .brake, .logic_supply_halt_state, .supply_fault_status, .functional_fault_status, .clear_pending);

// ==== sim/mcu_model.sv ====
// Partner: host controller writing clears and toggling enables
`timescale 1ns/1ps
module mcu_model
(
  // Clock
  input  wire logic sys_clk,
  // Host pins towards the device
  output logic      clear_faults_field,
  output logic      latch_clear_field,
  output logic      driver_enable_pin,
  output logic      chip_enable_raw
);
  // Idle: no clear, both enables up
  initial
  begin
    clear_faults_field = 1'b0;
    latch_clear_field  = 1'b0;
    driver_enable_pin  = 1'b1;
    chip_enable_raw    = 1'b1;
  end
  // One-cycle clear write, launched after a falling edge
  task strobe(input logic latch);
    @(negedge sys_clk);
    if (latch)
      latch_clear_field = 1'b1;
    else
      clear_faults_field = 1'b1;
    @(negedge sys_clk);
    clear_faults_field = 1'b0;
    latch_clear_field  = 1'b0;
  endtask : strobe
  // Low-high toggle of both enables, long enough for the filter
  task toggle;
    driver_enable_pin = 1'b0;
    chip_enable_raw   = 1'b0;
    repeat (8) @(negedge sys_clk);
    driver_enable_pin = 1'b1;
    chip_enable_raw   = 1'b1;
    repeat (8) @(negedge sys_clk);
  endtask : toggle
endmodule : mcu_model

// ==== sim/fault_arbitration_handler_bench.sv ====
// Testbench: table of single faults, then arbitration and shunt cases
`timescale 1ns/1ps
module fault_arbitration_handler_bench;
  import fault_arb_pkg::*;
  // Row: raw source index, expected status, gate action, hold, latch
  typedef struct {int src; logic [7:0] sup; logic [7:0] fun; logic hiz; logic hold; logic latch;} row_s;
  logic                sys_clk = 1'b0;
  logic                rst_n = 1'b0;
  logic [11:0]         raw = 12'h000;   // Raw detector levels
  logic                pwm_period_end = 1'b0;
  logic [1:0]          shunt_oc_mode = 2'h0;
  logic                shunt_oc_latch_cfg = 1'b0;
  logic                shunt_oc_truncate_cfg = 1'b0;
  logic                brake_on_shunt_overcurrent = 1'b0;
  logic                wdog_latch_cfg = 1'b0;
  logic                standby_state = 1'b0;
  logic                pump_start_blank = 1'b0;
  logic                logic_supply_good = 1'b1;
  logic                clear_faults_field, latch_clear_field, driver_enable_pin, chip_enable_raw;
  logic                fault_out_n, gate_hiz, pwm_truncate, brake, logic_supply_halt_state;
  logic                overheat_warning, clear_pending;
  logic [SUP_N-1:0]    supply_fault_status;
  logic [FUN_N-1:0]    functional_fault_status;
  int                  n_mismatch = 0;
  int                  n_tests = 0;
  int                  cnt = 0;
  row_s rows [10] = '{'{0, 8'h01, 8'h01, 1, 1, 0}, '{1, 8'h02, 8'h00, 0, 0, 0}, '{2, 8'h08, 8'h00, 0, 0, 0},
    '{3, 8'h04, 8'h00, 0, 0, 0}, '{4, 8'h00, 8'h02, 1, 0, 0}, '{5, 8'h00, 8'h04, 1, 0, 0},
    '{6, 8'h00, 8'h08, 1, 1, 1}, '{8, 8'h00, 8'h10, 0, 0, 0}, '{9, 8'h00, 8'h20, 1, 1, 1},
    '{11, 8'h00, 8'h80, 1, 1, 1}};
  // Clock and a PWM period mark every 16 cycles
  always #2.5 sys_clk = ~sys_clk;
  always @(negedge sys_clk)
  begin
    cnt = (cnt + 1) % 16;
    pwm_period_end = (cnt == 0);
  end
  // ==========================================================================
  // Design and host partner
  // ==========================================================================
  fault_arbitration_handler dut_u (.sys_clk, .rst_n, .logic_uv_raw(raw[0]), .logic_ov_raw(raw[1]),
    .logic_oc_raw(raw[2]), .buck_oc_raw(raw[3]), .pump_ls_uv_raw(raw[4]), .pump_hs_uv_raw(raw[5]),
    .overheat_shutdown_raw(raw[6]), .overheat_warning_raw(raw[7]), .shunt_oc_raw(raw[8]),
    .rotor_lock_raw(raw[9]), .wdog_raw(raw[10]), .nvm_fault_raw(raw[11]), .chip_enable_raw, .driver_enable_pin,
    .pwm_period_end, .standby_state, .pump_start_blank, .logic_supply_good, .shunt_oc_mode,
    .shunt_oc_latch_cfg, .shunt_oc_truncate_cfg, .brake_on_shunt_overcurrent, .wdog_latch_cfg,
    .clear_faults_field, .latch_clear_field, .fault_out_n, .gate_hiz, .pwm_truncate, .brake,
    .logic_supply_halt_state, .supply_fault_status, .functional_fault_status, .overheat_warning, .clear_pending);
  mcu_model host_u (.sys_clk, .clear_faults_field, .latch_clear_field, .driver_enable_pin, .chip_enable_raw);
  // ==========================================================================
  // Helpers
  // ==========================================================================
  task conclude;
    $display("n_tests=%0d n_mismatch=%0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : conclude
  task check(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  // Bounded wait for the pin to fall, then outputs settle
  task wait_pin;
    for (int i = 0; i < 40 && fault_out_n !== 1'b0; i++)
      @(negedge sys_clk);
    if (fault_out_n !== 1'b0)
    begin
      n_mismatch++;
      conclude();
    end
    repeat (3) @(negedge sys_clk);
  endtask : wait_pin
  task idle_check;
    check({3'h0, supply_fault_status}, 8'h00);
    check(functional_fault_status, 8'h00);
    check({7'h00, fault_out_n}, 8'h01);
  endtask : idle_check
  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial
  begin
    repeat (2) @(negedge sys_clk);
    rst_n = 1'b1;
    @(negedge sys_clk);
    idle_check();
    foreach (rows[k])
    begin
      raw[rows[k].src] = 1'b1;
      wait_pin();
      check({3'h0, supply_fault_status}, rows[k].sup);
      check(functional_fault_status, rows[k].fun);
      check({7'h00, gate_hiz}, {7'h00, rows[k].hiz});
      check({7'h00, logic_supply_halt_state}, {7'h00, rows[k].src == 0});
      raw[rows[k].src] = 1'b0;
      repeat (10) @(negedge sys_clk);
      check(functional_fault_status, rows[k].fun);
      check({7'h00, gate_hiz}, {7'h00, rows[k].hiz & rows[k].hold});
      host_u.toggle();
      host_u.strobe(1'b0);
      repeat (3) @(negedge sys_clk);
      if (rows[k].latch)
      begin
        check(functional_fault_status, rows[k].fun);
        host_u.strobe(1'b1);
        repeat (3) @(negedge sys_clk);
      end
      idle_check();
    end
    // Same-cycle shunt and nvm: shunt outranks, nvm only recorded
    shunt_oc_truncate_cfg = 1'b1;
    raw[8] = 1'b1;
    raw[11] = 1'b1;
    wait_pin();
    check({7'h00, pwm_truncate}, 8'h01);
    check({7'h00, gate_hiz}, 8'h00);
    check(functional_fault_status, 8'h90);
    host_u.strobe(1'b0);
    repeat (3) @(negedge sys_clk);
    check(functional_fault_status, 8'h90);
    check({7'h00, fault_out_n}, 8'h00);
    raw[8] = 1'b0;
    raw[11] = 1'b0;
    repeat (10) @(negedge sys_clk);
    host_u.strobe(1'b0);
    host_u.strobe(1'b1);
    repeat (3) @(negedge sys_clk);
    idle_check();
    // Latched immediate shunt with braking
    shunt_oc_latch_cfg = 1'b1;
    brake_on_shunt_overcurrent = 1'b1;
    raw[8] = 1'b1;
    wait_pin();
    check({7'h00, brake}, 8'h01);
    host_u.strobe(1'b1);
    repeat (3) @(negedge sys_clk);
    check(functional_fault_status, 8'h10);
    raw[8] = 1'b0;
    repeat (10) @(negedge sys_clk);
    host_u.strobe(1'b0);
    repeat (3) @(negedge sys_clk);
    check(functional_fault_status, 8'h10);
    host_u.strobe(1'b1);
    repeat (3) @(negedge sys_clk);
    idle_check();
    check({7'h00, brake}, 8'h00);
    // Counting shunt mode: event recorded at once, cleared after quiet period
    brake_on_shunt_overcurrent = 1'b0;
    shunt_oc_mode = OC_COUNT8;
    raw[8] = 1'b1;
    repeat (8) @(negedge sys_clk);
    raw[8] = 1'b0;
    repeat (6) @(negedge sys_clk);
    check(functional_fault_status, 8'h10);
    host_u.strobe(1'b1);
    check(functional_fault_status, 8'h10);
    repeat (40) @(negedge sys_clk);
    host_u.strobe(1'b1);
    host_u.strobe(1'b0);
    repeat (3) @(negedge sys_clk);
    idle_check();
    // Counting shunt: standby lets the latch go before a quiet period
    raw[8] = 1'b1;
    repeat (8) @(negedge sys_clk);
    raw[8] = 1'b0;
    repeat (6) @(negedge sys_clk);
    standby_state = 1'b1;
    host_u.strobe(1'b1);
    standby_state = 1'b0;
    repeat (3) @(negedge sys_clk);
    idle_check();
    // Warning and latched watchdog: status only, pin stays high
    wdog_latch_cfg = 1'b1;
    raw[7] = 1'b1;
    raw[10] = 1'b1;
    repeat (10) @(negedge sys_clk);
    check({7'h00, overheat_warning}, 8'h01);
    check(functional_fault_status, 8'h40);
    check({7'h00, fault_out_n}, 8'h01);
    raw[7] = 1'b0;
    raw[10] = 1'b0;
    repeat (10) @(negedge sys_clk);
    host_u.strobe(1'b0);
    check(functional_fault_status, 8'h40);
    host_u.strobe(1'b1);
    repeat (3) @(negedge sys_clk);
    idle_check();
    check({7'h00, overheat_warning}, 8'h00);
    // Supply qualifiers: buck blanked, logic over-voltage needs a good supply
    pump_start_blank = 1'b1;
    raw[3] = 1'b1;
    repeat (10) @(negedge sys_clk);
    check({3'h0, supply_fault_status}, 8'h00);
    pump_start_blank = 1'b0;
    logic_supply_good = 1'b0;
    raw[3] = 1'b0;
    raw[1] = 1'b1;
    repeat (10) @(negedge sys_clk);
    raw[1] = 1'b0;
    repeat (10) @(negedge sys_clk);
    logic_supply_good = 1'b1;
    idle_check();
    conclude();
  end
endmodule : fault_arbitration_handler_bench
